// *** design/aoc_top.sv ***
// Always-on free-running counter and periodic reloading timer
`timescale 1ns/1ns
`default_nettype none

module aoc_top
    import aoc_pkg::*;
(
    input  wire logic               i_clock,
    input  wire logic               i_sys_rst,
    input  wire logic               i_rtc_clock,
    input  wire logic               i_slow_timer_clock_enable,
    input  wire logic               i_free_counter_enable,
    input  wire logic [COUNT_W-1:0] i_periodic_load_value,
    input  wire logic               i_alarm_clear_write,
    input  wire logic               i_reload_request_write,
    output logic      [COUNT_W-1:0] o_free_count,
    output logic      [COUNT_W-1:0] o_periodic_count_value,
    output logic                    o_alarm_clear_bit,
    output logic                    o_reload_request_bit,
    output logic                    o_alarm
);

    // Slow clock edge detection
    logic rtc_level;
    logic next_rtc_level;
    logic slow_tick;

    // Free-running counter
    logic [COUNT_W-1:0] free_count;
    logic [COUNT_W-1:0] next_free_count;

    // Periodic timer state
    logic [COUNT_W-1:0] load_slow;
    logic [COUNT_W-1:0] next_load_slow;
    logic [COUNT_W-1:0] periodic_count;
    logic [COUNT_W-1:0] next_periodic_count;
    logic [COUNT_W-1:0] count_snapshot;
    logic [COUNT_W-1:0] next_count_snapshot;
    aoc_pt_state_t      pt_state;
    aoc_pt_state_t      next_pt_state;
    logic               expiry;

    // Alarm flag
    logic alarm;
    logic next_alarm;

    // Request trackers for the two self-clearing bits
    aoc_req_if clear_req ();
    aoc_req_if reload_req ();

    // Gated slow tick: a rising edge of the real-time clock while its clock is enabled
    assign slow_tick      = i_rtc_clock & ~rtc_level & i_slow_timer_clock_enable;
    assign next_rtc_level = i_rtc_clock;

    // Remember the previous real-time clock level
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rtc_level <= SLOW_LEVEL_RESET;
        end else begin
            rtc_level <= next_rtc_level;
        end
    end

    // Wire up the two trackers
    assign clear_req.set_req  = i_alarm_clear_write;
    assign clear_req.tick     = slow_tick;
    assign reload_req.set_req = i_reload_request_write;
    assign reload_req.tick    = slow_tick;

    aoc_req_tracker u_clear_tracker (
        .i_clock   (i_clock),
        .i_sys_rst (i_sys_rst),
        .req       (clear_req.tracker)
    );

    aoc_req_tracker u_reload_tracker (
        .i_clock   (i_clock),
        .i_sys_rst (i_sys_rst),
        .req       (reload_req.tracker)
    );

    // Free counter: one step per slow tick while enabled, hold otherwise
    always_comb begin
        next_free_count = free_count;
        if (slow_tick && i_free_counter_enable) begin
            next_free_count = free_count + COUNT_STEP;
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            free_count <= FREE_COUNT_RESET;
        end else begin
            free_count <= next_free_count;
        end
    end

    // Load value is taken into the slow domain only on a slow tick
    always_comb begin
        next_load_slow = load_slow;
        if (slow_tick) begin
            next_load_slow = i_periodic_load_value;
        end
    end

    // Expiry: count is at one on a tick while running, and reloads instead of stepping to zero
    assign expiry = slow_tick && (pt_state == AOC_PT_RUNNING) && !reload_req.done
                    && (periodic_count == (EXPIRY_COUNT + COUNT_STEP));

    // Periodic timer: reload on request, decrement while enabled, reload at expiry
    always_comb begin
        next_periodic_count = periodic_count;
        next_pt_state       = pt_state;
        if (slow_tick) begin
            if (reload_req.done) begin
                next_periodic_count = i_periodic_load_value;
                next_pt_state       = (i_periodic_load_value == EXPIRY_COUNT) ?
                                      AOC_PT_STOPPED : AOC_PT_RUNNING;
            end else begin
                case (pt_state)
                    AOC_PT_STOPPED: begin
                        if (load_slow != EXPIRY_COUNT) begin
                            next_pt_state = AOC_PT_RELOADING;
                        end
                    end
                    AOC_PT_RELOADING: begin
                        if (load_slow == EXPIRY_COUNT) begin
                            next_pt_state = AOC_PT_STOPPED;
                        end else begin
                            next_periodic_count = load_slow;
                            next_pt_state       = AOC_PT_RUNNING;
                        end
                    end
                    AOC_PT_RUNNING: begin
                        if (load_slow == EXPIRY_COUNT) begin
                            next_pt_state = AOC_PT_STOPPED;
                        end else if (expiry || periodic_count == EXPIRY_COUNT) begin
                            next_periodic_count = load_slow;
                        end else begin
                            next_periodic_count = periodic_count - COUNT_STEP;
                        end
                    end
                    default: begin
                        next_pt_state = AOC_PT_STOPPED;
                    end
                endcase
            end
        end
    end

    // Read copy lags the live count by one slow tick
    always_comb begin
        next_count_snapshot = count_snapshot;
        if (slow_tick) begin
            next_count_snapshot = periodic_count;
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            load_slow      <= PERIODIC_LOAD_RESET;
            periodic_count <= PERIODIC_COUNT_RESET;
            count_snapshot <= PERIODIC_COUNT_RESET;
            pt_state       <= AOC_PT_STOPPED;
        end else begin
            load_slow      <= next_load_slow;
            periodic_count <= next_periodic_count;
            count_snapshot <= next_count_snapshot;
            pt_state       <= next_pt_state;
        end
    end

    // Alarm: set on expiry, cleared when a clear request completes; set wins
    always_comb begin
        next_alarm = alarm;
        if (clear_req.done) begin
            next_alarm = 1'b0;
        end
        if (expiry) begin
            next_alarm = 1'b1;
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            alarm <= ALARM_RESET;
        end else begin
            alarm <= next_alarm;
        end
    end

    // Outputs
    assign o_free_count           = free_count;
    assign o_periodic_count_value = count_snapshot;
    assign o_alarm_clear_bit      = clear_req.pending;
    assign o_reload_request_bit   = reload_req.pending;
    assign o_alarm                = alarm;

endmodule

`default_nettype wire

// *** design/aoc_pkg.sv ***
// Shared constants and types for the always-on counter pair
package aoc_pkg;

    // Counter width of both always-on counters
    localparam int unsigned COUNT_W = 32;

    // Nominal rate of the slow real-time clock, in hertz
    localparam int unsigned SLOW_CLOCK_HZ = 32768;

    // System clock rate, in hertz
    localparam int unsigned SYS_CLOCK_HZ = 100000000;

    // Values after reset
    localparam logic [COUNT_W-1:0] FREE_COUNT_RESET     = 32'h0000_0000;
    localparam logic [COUNT_W-1:0] PERIODIC_COUNT_RESET = 32'h0000_0000;
    localparam logic [COUNT_W-1:0] PERIODIC_LOAD_RESET  = 32'h0000_0000;
    localparam logic               ALARM_RESET          = 1'b0;
    localparam logic               REQUEST_RESET        = 1'b0;
    localparam logic               SLOW_LEVEL_RESET     = 1'b0;

    // Count value the periodic timer reloads instead of reaching; expiry fires one step above it
    localparam logic [COUNT_W-1:0] EXPIRY_COUNT = 32'h0000_0000;

    // Amount added or removed per slow tick
    localparam logic [COUNT_W-1:0] COUNT_STEP = 32'h0000_0001;

    // Periodic timer activity, seen in the slow domain
    typedef enum logic [1:0] {
        AOC_PT_STOPPED,
        AOC_PT_RUNNING,
        AOC_PT_RELOADING
    } aoc_pt_state_t;

endpackage

// *** design/aoc_req_if.sv ***
// Request and completion signals between the counter pair and a request tracker
`timescale 1ns/1ns
`default_nettype none

interface aoc_req_if;
    logic set_req;   // Software writes one to the bit
    logic tick;      // Slow-domain edge on which the action is carried out
    logic pending;   // Bit as software reads it
    logic done;      // Action carried out on this tick

    modport owner (
        output set_req,
        output tick,
        input  pending,
        input  done
    );

    modport tracker (
        input  set_req,
        input  tick,
        output pending,
        output done
    );
endinterface

`default_nettype wire

// *** design/aoc_req_tracker.sv ***
// Self-clearing control bit that waits for one slow-domain tick
`timescale 1ns/1ns
`default_nettype none

module aoc_req_tracker
    import aoc_pkg::*;
(
    input  wire logic   i_clock,
    input  wire logic   i_sys_rst,
    aoc_req_if.tracker  req
);

    logic pending;
    logic next_pending;

    // Action completes on the first slow tick seen while the bit is set
    assign req.done    = pending & req.tick;
    assign req.pending = pending;

    // A new write wins over completion in the same cycle
    always_comb begin
        next_pending = pending;
        if (req.done) begin
            next_pending = 1'b0;
        end
        if (req.set_req) begin
            next_pending = 1'b1;
        end
    end

    // Register the bit
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pending <= REQUEST_RESET;
        end else begin
            pending <= next_pending;
        end
    end

endmodule

`default_nettype wire

// *** verification/aoc_props.sv ***
// Port checker for the always-on counter pair
`timescale 1ns/1ns
`default_nettype none

module aoc_props
    import aoc_pkg::*;
(
    input wire logic               i_clock,
    input wire logic               i_sys_rst,
    input wire logic               i_rtc_clock,
    input wire logic               i_slow_timer_clock_enable,
    input wire logic               i_free_counter_enable,
    input wire logic [COUNT_W-1:0] i_periodic_load_value,
    input wire logic               i_alarm_clear_write,
    input wire logic               i_reload_request_write,
    input wire logic [COUNT_W-1:0] o_free_count,
    input wire logic [COUNT_W-1:0] o_periodic_count_value,
    input wire logic               o_alarm_clear_bit,
    input wire logic               o_reload_request_bit,
    input wire logic               o_alarm
);
    logic rtc_q;
    logic next_rtc_q;
    logic tick;

    // Slow tick rebuilt from the sampled slow clock level and the gate
    always_comb begin
        next_rtc_q = i_rtc_clock;
    end
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rtc_q <= 1'b0;
        end else begin
            rtc_q <= next_rtc_q;
        end
    end
    assign tick = i_rtc_clock & ~rtc_q & i_slow_timer_clock_enable;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);

    // Counter steps and holds
    property p_free_inc; tick && i_free_counter_enable |=> o_free_count == $past(o_free_count) + COUNT_STEP; endproperty
    a_free_inc: assert property (p_free_inc) else $error("free count did not step");
    property p_free_hold; !(tick && i_free_counter_enable) |=> $stable(o_free_count); endproperty
    a_free_hold: assert property (p_free_hold) else $error("free count moved");
    property p_pcnt_hold; !tick |=> $stable(o_periodic_count_value); endproperty
    a_pcnt_hold: assert property (p_pcnt_hold) else $error("periodic count moved off tick");
    // Self-clearing request bits
    property p_rl_set; i_reload_request_write |=> o_reload_request_bit; endproperty
    a_rl_set: assert property (p_rl_set) else $error("reload bit not set");
    property p_rl_done; o_reload_request_bit && tick && !i_reload_request_write |=> !o_reload_request_bit; endproperty
    a_rl_done: assert property (p_rl_done) else $error("reload bit not cleared");
    property p_clr_done; o_alarm_clear_bit && tick && !i_alarm_clear_write |=> !o_alarm_clear_bit; endproperty
    a_clr_done: assert property (p_clr_done) else $error("clear bit not cleared");
    // Alarm raised on a tick and held until cleared
    property p_alarm_hold; o_alarm && !(o_alarm_clear_bit && tick) |=> o_alarm; endproperty
    a_alarm_hold: assert property (p_alarm_hold) else $error("alarm dropped early");
    property p_alarm_rise; $rose(o_alarm) |-> $past(tick); endproperty
    a_alarm_rise: assert property (p_alarm_rise) else $error("alarm rose off tick");

    c_alarm: cover property ($rose(o_alarm));
    c_reload: cover property ($fell(o_reload_request_bit));
    c_clear: cover property ($fell(o_alarm_clear_bit));
endmodule

`default_nettype wire

// *** verification/aoc_rtc_model.sv ***
// Slow real-time oscillator model, phase offset from the system clock
`timescale 1ns/1ns
`default_nettype none

module aoc_rtc_model #(
    parameter int HALF_NS = 80
) (
    output var logic o_rtc
);
    // Free-running square wave; edges kept away from system clock edges
    initial begin
        o_rtc = 1'b0;
        #3;
        forever #(HALF_NS) o_rtc = ~o_rtc;
    end
endmodule

`default_nettype wire

// *** verification/aoc_top_tb.sv ***
// Self-checking bench for the always-on counter pair
`timescale 1ns/1ns
`default_nettype none

module aoc_top_tb;
    import aoc_pkg::*;
    localparam int PER = 16;
    localparam logic [COUNT_W-1:0] LOAD = 32'h0000_0005;
    logic               clk = 1'b0;
    logic               rst = 1'b1;
    logic               rtc;
    logic               gate = 1'b1;
    logic               fen = 1'b0;
    logic [COUNT_W-1:0] load = 32'h0000_0000;
    logic               clr_w = 1'b0;
    logic               rl_w = 1'b0;
    logic [COUNT_W-1:0] fcnt;
    logic [COUNT_W-1:0] pcnt;
    logic               clr_b;
    logic               rl_b;
    logic               alarm;
    int                 errors = 0;
    int                 tests_run = 0;
    int                 cyc = 0;
    int                 n;
    int                 stamp;
    logic [COUNT_W-1:0] snap;

    always #5 clk = ~clk;
    always @(posedge clk) cyc++;

    aoc_rtc_model #(.HALF_NS(PER * 5)) rtc_src (.o_rtc(rtc));

    aoc_top dut (.i_clock(clk), .i_sys_rst(rst), .i_rtc_clock(rtc), .i_slow_timer_clock_enable(gate),
        .i_free_counter_enable(fen), .i_periodic_load_value(load), .i_alarm_clear_write(clr_w),
        .i_reload_request_write(rl_w), .o_free_count(fcnt), .o_periodic_count_value(pcnt),
        .o_alarm_clear_bit(clr_b), .o_reload_request_bit(rl_b), .o_alarm(alarm));

    task automatic check(input logic [COUNT_W-1:0] seen, input logic [COUNT_W-1:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One-cycle write of one to the reload bit (rl=1) or the clear bit
    task automatic pulse(input logic rl);
        @(negedge clk);
        rl_w = rl;
        clr_w = ~rl;
        @(negedge clk);
        rl_w = 1'b0;
        clr_w = 1'b0;
    endtask

    // Bounded wait on a condition picked by sel: 0 reload done, 1 clear done, 2 alarm, 3 free count nonzero
    task automatic wait_for(input int sel);
        n = 0;
        while (!(sel == 0 ? rl_b === 1'b0 : sel == 1 ? clr_b === 1'b0 : sel == 2 ? alarm === 1'b1
                 : fcnt !== 32'h0) && n < 20 * PER) begin
            @(negedge clk);
            n++;
        end
        check(32'(n < 20 * PER), 32'h1);
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #60000;
        errors++;
        summarize();
    end

    initial begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        check(fcnt, FREE_COUNT_RESET);
        check(pcnt, PERIODIC_COUNT_RESET);
        check({29'h0000_0000, alarm, rl_b, clr_b}, 32'h0000_0000);
        $display("reset values done");
        fen = 1'b1;
        wait_for(3);
        snap = fcnt;
        repeat (10 * PER) @(negedge clk);
        check(fcnt, snap + 32'h0000_000A);
        fen = 1'b0;
        snap = fcnt;
        repeat (4 * PER) @(negedge clk);
        check(fcnt, snap);
        fen = 1'b1;
        $display("free counter done");
        load = LOAD;
        pulse(1'b1);
        check(rl_b, 1'b1);
        wait_for(0);
        stamp = cyc;
        repeat (PER) @(negedge clk);
        check(pcnt, LOAD);
        repeat (PER) @(negedge clk);
        check(pcnt, LOAD - COUNT_STEP);
        wait_for(2);
        check(32'(cyc - stamp), 32'(PER * 5));
        stamp = cyc;
        pulse(1'b0);
        wait_for(1);
        check(alarm, 1'b0);
        wait_for(2);
        check(32'(cyc - stamp), 32'(PER * 5));
        $display("periodic timer done");
        load = 32'h0000_0000;
        pulse(1'b0);
        wait_for(1);
        repeat (15 * PER) @(negedge clk);
        check(alarm, 1'b0);
        $display("alarm clear done");
        gate = 1'b0;
        load = LOAD;
        snap = fcnt;
        pulse(1'b1);
        repeat (3 * PER) @(negedge clk);
        check(fcnt, snap);
        check(rl_b, 1'b1);
        gate = 1'b1;
        wait_for(0);
        $display("clock gate done");
        summarize();
    end
endmodule

bind aoc_top aoc_props u_props (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_rtc_clock(i_rtc_clock),
    .i_slow_timer_clock_enable(i_slow_timer_clock_enable), .i_free_counter_enable(i_free_counter_enable),
    .i_periodic_load_value(i_periodic_load_value), .i_alarm_clear_write(i_alarm_clear_write),
    .i_reload_request_write(i_reload_request_write), .o_free_count(o_free_count),
    .o_periodic_count_value(o_periodic_count_value), .o_alarm_clear_bit(o_alarm_clear_bit),
    .o_reload_request_bit(o_reload_request_bit), .o_alarm(o_alarm));

`default_nettype wire
